//--- common/sensor_ctrl_map.vh
// Constants for the sensor system control block: modes, output modes, timing, codes.
// Assumes a 250 MHz core clock standing in for the internal oscillator.
`ifndef SENSOR_CTRL_MAP_VH
`define SENSOR_CTRL_MAP_VH

// Working modes
`define WMODE_NORMAL      2'h0
`define WMODE_COMMAND     2'h1
`define WMODE_DIAG        2'h2

// Output modes
`define OMODE_ONEWIRE_ONLY  2'h0
`define OMODE_WINDOW        2'h1
`define OMODE_ANALOG_SHARED 2'h2
`define OMODE_ONEWIRE_DIS   2'h3

// Timing figures and cycle counts at 250 MHz
`define CLK_MHZ           250
`define SETTLE_MIN_US     500
`define SETTLE_CYC        (`SETTLE_MIN_US * `CLK_MHZ)
`define CONFIG_US         200
`define CONFIG_CYC        (`CONFIG_US * `CLK_MHZ)
`define WINDOW_MS         500
`define WINDOW_CYC        (`WINDOW_MS * 1000 * `CLK_MHZ)
`define START_CONV_COUNT  5

// Result format and fixed output levels
`define RESULT_MAX        15'h7fff
`define ERROR_CODE        16'hffff
`define DIAG_LOW_CODE     16'h0000

`endif

//--- core/sensor_system_control.v
// Sensor system control: startup sequencing, working modes, conditioning, output mode, failsafe.
// Assumes the clock is the oscillator, inputs are synchronous, and serial framing lies outside.
// Functional notes
// [R1] Exactly one working mode: normal, calibration command, or diagnostic.
// [R2] Shared output pin stays high impedance during supply settling.
// [R3] All startup durations are counted in clock cycles, scaling with frequency.
// [R4] Configuration load and signature check drive the lower diagnostic level.
// [R5] Start routine lasts five conversions; pin low or tri-state by output mode.
// [R6] A startup error enters diagnostic mode and holds the lower level.
// [R7] After startup conditioning runs; window mode delays analog until window ends. Code conditions only in the run phase, not in the window phase.
// [R8] Offset, temperature and up to third-order nonlinearity are corrected.
// [R9] Result is a non-negative 15-bit fraction readable on both serial links.
// [R10] Analog output value is clipped to programmed lower and upper limits.
// [R11] Temperature term holds first and second order coefficients.
// [R12] One-wire-only mode disables analog output and allows one-wire readout.
// [R13] Window mode starts analog only if no communication inside the window.
// [R14] Analog-shared mode drives analog at once, command entry still accepted.
// [R15] One-wire-disabled mode drives analog and refuses one-wire readout.
// [R16] Output mode comes from stored configuration, or a received command.
// [R17] Analog value is a 12.4-bit resistor-string code.
// [R18] Any failure gives diagnostic mode, low level and an error code on reads. Code ignores failures while supply settling runs.
// [R19] Watchdog flags a failure when the controller stops confirming.
// [R20] Oscillator failure detection triggers the diagnostic state.
// [R21] Memory check errors and control register parity mismatch are failures.
// [R22] Bridge open, bridge short and optional temperature sensor faults are failures.
// [R23] Command entry inside the window enters command mode without analog output.
//
// The strobed command and read ports were chosen for this implementation.
`timescale 1ns/1ps
`include "sensor_ctrl_map.vh"

module sensor_system_control #(
  parameter SETTLE_CYCLES = `SETTLE_CYC,
  parameter CONFIG_CYCLES = `CONFIG_CYC,
  parameter WINDOW_CYCLES = `WINDOW_CYC,
  parameter WDOG_CYCLES   = 1024,
  parameter CONV_CYCLES   = 4096
) (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        nrst_in,
  // Stored configuration
  input  wire [1:0]  cfg_out_mode_in,
  input  wire        cfg_signature_ok_in,
  input  wire        cfg_load_done_in,
  input  wire        cfg_parity_in,
  input  wire        temp_check_en_in,
  // Coefficients, signed Q1.15; limits, unsigned 15-bit
  input  wire [15:0] coef_offset_in,
  input  wire [15:0] coef_gain_in,
  input  wire [15:0] coef_tc1_in,
  input  wire [15:0] coef_tc2_in,
  input  wire [15:0] coef_nl2_in,
  input  wire [15:0] coef_nl3_in,
  input  wire [14:0] limit_low_in,
  input  wire [14:0] limit_high_in,
  // Converter samples
  input  wire        sample_valid_in,
  input  wire [15:0] bridge_raw_in,
  input  wire [15:0] temp_raw_in,
  // Serial command side
  input  wire        cmd_enter_in,
  input  wire        cmd_set_mode_in,
  input  wire [1:0]  cmd_mode_in,
  input  wire        cmd_exit_in,
  input  wire        comm_activity_in,
  input  wire        read_onewire_in,
  input  wire        read_i2c_in,
  // Failure sources
  input  wire        wdog_kick_in,
  input  wire        osc_fail_in,
  input  wire        mem_check_err_in,
  input  wire        bridge_open_in,
  input  wire        bridge_short_in,
  input  wire        temp_fault_in,
  // Shared pin and results
  output wire [15:0] dac_code_out,
  output wire        pin_drive_en_out,
  output wire        analog_active_out,
  output wire [1:0]  work_mode_out,
  output wire [1:0]  out_mode_out,
  output wire        startup_done_out,
  output wire        window_open_out,
  output reg  [15:0] read_data_out,
  output reg         read_valid_out,
  output reg         read_refused_out,
  output wire        fail_out
);

  // ************************************************************
  // Startup phases
  // ************************************************************
  localparam PH_SETTLE = 3'h0;
  localparam PH_CONFIG = 3'h1;
  localparam PH_START  = 3'h2;
  localparam PH_WINDOW = 3'h3;
  localparam PH_RUN    = 3'h4;

  reg [2:0]  phase_r,      phase_nxt;
  reg [1:0]  wmode_r,      wmode_nxt;
  reg [1:0]  omode_r,      omode_nxt;
  reg [31:0] cnt_r,        cnt_nxt;
  reg [2:0]  conv_r,       conv_nxt;
  reg        analog_r,     analog_nxt;
  reg        window_r,     window_nxt;
  reg        done_r,       done_nxt;
  reg        fail_r;
  reg [15:0] wdog_r;
  reg [14:0] result_r;
  reg [15:0] dac_r;

  // ************************************************************
  // Failsafe
  // ************************************************************
  wire wdog_expired = (wdog_r >= WDOG_CYCLES[15:0]);
  // Parity is even over coefficients, limits, output mode plus the stored parity bit
  wire parity_err = ^{coef_offset_in, coef_gain_in, coef_tc1_in, coef_tc2_in,
                      coef_nl2_in, coef_nl3_in, limit_low_in, limit_high_in,
                      cfg_out_mode_in, cfg_parity_in};
  wire fail_now = wdog_expired                                     // [R19]
                | osc_fail_in                                      // [R20]
                | mem_check_err_in | parity_err                    // [R21]
                | bridge_open_in | bridge_short_in                 // [R22]
                | (temp_check_en_in & temp_fault_in);              // [R22]

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdog_r <= 16'h0000;
    end else if (wdog_kick_in) begin
      wdog_r <= 16'h0000;
    end else if (!wdog_expired) begin
      wdog_r <= wdog_r + 16'h0001;                                 // [R19]
    end
  end

  // Sticky failure; only reset clears it so a diagnosis cannot flicker away
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fail_r <= 1'b0;
    end else if (fail_now && phase_r != PH_SETTLE) begin
      fail_r <= 1'b1;                                              // [R18]
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @* begin
    phase_nxt  = phase_r;
    wmode_nxt  = wmode_r;
    omode_nxt  = omode_r;
    cnt_nxt    = cnt_r + 32'h1;                                    // [R3]
    conv_nxt   = conv_r;
    analog_nxt = analog_r;
    window_nxt = window_r;
    done_nxt   = done_r;
    if (cmd_set_mode_in && wmode_r == `WMODE_COMMAND) begin
      omode_nxt = cmd_mode_in;                                     // [R16]
    end
    case (phase_r)
      PH_SETTLE: begin
        if (cnt_r >= SETTLE_CYCLES - 1) begin                      // [R2]
          phase_nxt = PH_CONFIG;
          cnt_nxt   = 32'h0;
        end
      end
      PH_CONFIG: begin
        if (cfg_load_done_in || cnt_r >= CONFIG_CYCLES - 1) begin  // [R4]
          omode_nxt = cfg_out_mode_in;                             // [R16]
          cnt_nxt   = 32'h0;
          if (!cfg_signature_ok_in) begin
            wmode_nxt = `WMODE_DIAG;                               // [R6]
            phase_nxt = PH_RUN;
          end else begin
            phase_nxt = PH_START;
            conv_nxt  = 3'h0;
            window_nxt = (cfg_out_mode_in == `OMODE_WINDOW) ||
                         (cfg_out_mode_in == `OMODE_ANALOG_SHARED);
          end
        end
      end
      PH_START: begin
        if (cnt_r >= CONV_CYCLES - 1) begin
          cnt_nxt  = 32'h0;
          conv_nxt = conv_r + 3'h1;
          if (conv_r == `START_CONV_COUNT - 1) begin               // [R5]
            done_nxt = 1'b1;
            if (omode_r == `OMODE_WINDOW) begin
              phase_nxt = PH_WINDOW;                               // [R7]
            end else begin
              phase_nxt  = PH_RUN;
              analog_nxt = (omode_r != `OMODE_ONEWIRE_ONLY);       // [R12] [R14] [R15]
            end
          end
        end
      end
      PH_WINDOW: begin
        if (comm_activity_in) begin
          phase_nxt  = PH_RUN;                                     // [R13]
          window_nxt = 1'b0;
        end else if (cnt_r >= WINDOW_CYCLES - 1) begin
          phase_nxt  = PH_RUN;
          analog_nxt = 1'b1;                                       // [R13]
          window_nxt = 1'b0;
        end
      end
      PH_RUN: begin
        cnt_nxt = cnt_r;
        if (window_r && omode_r == `OMODE_ANALOG_SHARED) begin
          cnt_nxt = cnt_r + 32'h1;
          if (cnt_r >= WINDOW_CYCLES - 1) begin
            window_nxt = 1'b0;
          end
        end
        if (cmd_exit_in && wmode_r == `WMODE_COMMAND) begin
          wmode_nxt  = `WMODE_NORMAL;
          analog_nxt = (omode_r != `OMODE_ONEWIRE_ONLY);
        end
      end
      default: begin
        phase_nxt = PH_SETTLE;
      end
    endcase
    if (cmd_enter_in && window_r && wmode_r == `WMODE_NORMAL &&
        (phase_r == PH_START || phase_r == PH_WINDOW || phase_r == PH_RUN)) begin
      wmode_nxt  = `WMODE_COMMAND;                                 // [R23]
      analog_nxt = 1'b0;
      window_nxt = 1'b0;
      done_nxt   = 1'b1;
      phase_nxt  = PH_RUN;
      cnt_nxt    = 32'h0;
    end
    if (fail_r || (fail_now && phase_r != PH_SETTLE)) begin
      wmode_nxt  = `WMODE_DIAG;                                    // [R18] [R1]
      analog_nxt = 1'b0;
    end
  end

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r  <= PH_SETTLE;
      wmode_r  <= `WMODE_NORMAL;
      omode_r  <= `OMODE_ONEWIRE_DIS;
      cnt_r    <= 32'h0;
      conv_r   <= 3'h0;
      analog_r <= 1'b0;
      window_r <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      wmode_r  <= wmode_nxt;
      omode_r  <= omode_nxt;
      cnt_r    <= cnt_nxt;
      conv_r   <= conv_nxt;
      analog_r <= analog_nxt;
      window_r <= window_nxt;
      done_r   <= done_nxt;
    end
  end

  // ************************************************************
  // Conditioning
  // ************************************************************
  // Signed Q1.15 multiply, result rescaled to Q1.15
  function [15:0] qmul;
    input [15:0] a;
    input [15:0] b;
    reg signed [31:0] p;
    begin
      p    = $signed(a) * $signed(b);
      qmul = p[30:15];
    end
  endfunction

  // Saturating signed add
  function [15:0] qadd;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) begin
        qadd = s[16] ? 16'h8000 : 16'h7fff;
      end else begin
        qadd = s[15:0];
      end
    end
  endfunction

  wire [15:0] x0    = qadd(bridge_raw_in, coef_offset_in);          // [R8]
  wire [15:0] t2    = qmul(temp_raw_in, temp_raw_in);
  wire [15:0] tcorr = qadd(qadd(16'h7fff, qmul(coef_tc1_in, temp_raw_in)),
                           qmul(coef_tc2_in, t2));                 // [R11]
  wire [15:0] x1    = qmul(qmul(x0, coef_gain_in), tcorr);         // [R8]
  wire [15:0] xx    = qmul(x1, x1);
  wire [15:0] y     = qadd(qadd(x1, qmul(coef_nl2_in, xx)),
                           qmul(coef_nl3_in, qmul(xx, x1)));       // [R8]
  // Negative results floor at zero, positive ones stay below one
  wire [14:0] y15   = y[15] ? 15'h0000 : y[14:0];                  // [R9]
  wire [14:0] clip  = (y15 < limit_low_in)  ? limit_low_in  :
                      (y15 > limit_high_in) ? limit_high_in : y15; // [R10]

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_r <= 15'h0000;
      dac_r    <= `DIAG_LOW_CODE;
    end else begin
      if (sample_valid_in && phase_r == PH_RUN && wmode_r != `WMODE_DIAG) begin
        result_r <= y15;
        dac_r    <= {clip, 1'b0};                                  // [R17]
      end
      if (wmode_nxt == `WMODE_DIAG) begin
        dac_r <= `DIAG_LOW_CODE;                                   // [R6]
      end
    end
  end

  // ************************************************************
  // Serial readout
  // ************************************************************
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_data_out    <= 16'h0000;
      read_valid_out   <= 1'b0;
      read_refused_out <= 1'b0;
    end else begin
      read_valid_out   <= 1'b0;
      read_refused_out <= 1'b0;
      if (read_onewire_in && omode_r == `OMODE_ONEWIRE_DIS &&
          wmode_r != `WMODE_COMMAND) begin
        read_refused_out <= 1'b1;                                  // [R15]
      end else if (read_onewire_in || read_i2c_in) begin
        read_valid_out <= 1'b1;                                    // [R9] [R12]
        read_data_out  <= (wmode_r == `WMODE_DIAG) ? `ERROR_CODE
                                                   : {1'b0, result_r}; // [R18]
      end
    end
  end

  // ************************************************************
  // Shared pin
  // ************************************************************
  // Low level during config, in diag, or start routine in shared/disabled modes
  wire drive_low = (phase_r == PH_CONFIG) ||                       // [R4]
                   (wmode_r == `WMODE_DIAG) ||                     // [R6]
                   (phase_r == PH_START &&
                    (omode_r == `OMODE_ANALOG_SHARED ||
                     omode_r == `OMODE_ONEWIRE_DIS));              // [R5]

  assign pin_drive_en_out  = (phase_r != PH_SETTLE) && (drive_low || analog_r); // [R2]
  assign dac_code_out      = drive_low ? `DIAG_LOW_CODE : dac_r;
  assign analog_active_out = analog_r;
  assign work_mode_out     = wmode_r;
  assign out_mode_out      = omode_r;
  assign startup_done_out  = done_r;
  assign window_open_out   = window_r;
  assign fail_out          = fail_r;

endmodule // sensor_system_control

//--- dv/cal_master_model.sv
// Model of the external calibration and readout master.
// Assumes requests reach the block as one-cycle strobes and replies come one cycle later.
`timescale 1ns/1ps
module cal_master_model (
  // Clock
  input  wire        ref_clk_in,
  // Replies from the block
  input  wire [15:0] read_data_in,
  input  wire        read_valid_in,
  input  wire        read_refused_in,
  // Requests to the block
  output wire        cmd_enter_out,
  output wire        comm_activity_out,
  output wire        read_onewire_out,
  output wire        read_i2c_out,
  output wire        cmd_exit_out,
  output wire        cmd_set_mode_out,
  output reg  [1:0]  cmd_mode_out = 2'h0
);
  reg [5:0]  strobe_r = 6'h00;
  reg [15:0] data_r;
  reg        valid_r;
  reg        refused_r;
  assign {cmd_set_mode_out, cmd_exit_out, read_i2c_out, read_onewire_out, comm_activity_out,
          cmd_enter_out} = strobe_r;
  // ****************
  // One request: 0 entry, 1 traffic, 2 one-wire read, 3 serial read, 4 exit, 5 set mode
  // ****************
  // Pin overdrive is abstracted to a strobe; the caller picks the window moment
  task send(input [2:0] op, input [1:0] mode);
    begin
      @(posedge ref_clk_in);
      strobe_r <= 6'h01 << op;
      cmd_mode_out <= mode;
      @(posedge ref_clk_in);
      strobe_r <= 6'h00;
      // Reply stands one cycle only; take it at the edge that closes that cycle
      @(posedge ref_clk_in);
      data_r = read_data_in;
      valid_r = read_valid_in;
      refused_r = read_refused_in;
    end
  endtask
endmodule // cal_master_model

//--- dv/sensor_ctrl_chk.sv
// Checker for sensor_system_control: pin state, working mode and read answers.
// Assumes it sees only the design's ports; bound below with the settle length handed on.
`timescale 1ns/1ps
`include "sensor_ctrl_map.vh"
module sensor_ctrl_chk #(
  parameter SETTLE_CYCLES = 20
) (
  input wire        ref_clk_in,
  input wire        nrst_in,
  input wire        temp_check_en_in,
  input wire        read_onewire_in,
  input wire        read_i2c_in,
  input wire        osc_fail_in,
  input wire        mem_check_err_in,
  input wire        bridge_open_in,
  input wire        bridge_short_in,
  input wire        temp_fault_in,
  input wire [15:0] dac_code_out,
  input wire        pin_drive_en_out,
  input wire        analog_active_out,
  input wire [1:0]  work_mode_out,
  input wire [1:0]  out_mode_out,
  input wire [15:0] read_data_out,
  input wire        read_valid_out,
  input wire        read_refused_out
);
  // ****************
  // Cycle count since reset; failures only count once settling is over
  // ****************
  reg  [31:0] up_r;
  wire        live = up_r >= SETTLE_CYCLES;
  wire        diag = work_mode_out == `WMODE_DIAG;
  wire        cmd  = work_mode_out == `WMODE_COMMAND;
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      up_r <= 32'h0;
    else if (!live)
      up_r <= up_r + 32'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_settle_hiz; up_r + 32'h1 < SETTLE_CYCLES |-> !pin_drive_en_out; endproperty
  a_settle_hiz: assert property (p_settle_hiz) else $error("pin driven while settling");
  property p_diag_low; diag |-> pin_drive_en_out && dac_code_out == `DIAG_LOW_CODE; endproperty
  a_diag_low: assert property (p_diag_low) else $error("diag without low level");
  property p_osc; live && osc_fail_in |=> diag; endproperty
  a_osc: assert property (p_osc) else $error("clock fault not reported");
  property p_mem; live && mem_check_err_in |=> diag; endproperty
  a_mem: assert property (p_mem) else $error("memory fault not reported");
  property p_conn;
    live && (bridge_open_in || bridge_short_in || temp_check_en_in && temp_fault_in) |=> diag;
  endproperty
  a_conn: assert property (p_conn) else $error("sensor fault not reported");
  property p_i2c;
    read_i2c_in |=> read_valid_out && (!diag || read_data_out == `ERROR_CODE);
  endproperty
  a_i2c: assert property (p_i2c) else $error("serial read answer wrong");
  property p_refuse;
    read_onewire_in && out_mode_out == `OMODE_ONEWIRE_DIS && work_mode_out == `WMODE_NORMAL
      |=> read_refused_out && !read_valid_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("one-wire read not refused");
  property p_cmd; cmd || out_mode_out == `OMODE_ONEWIRE_ONLY |-> !analog_active_out; endproperty
  a_cmd: assert property (p_cmd) else $error("analog active where it must be off");
  c_diag: cover property (live && diag);
  c_cmd: cover property (cmd);
  c_analog: cover property ($rose(analog_active_out));
endmodule // sensor_ctrl_chk

bind sensor_system_control sensor_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sensor_ctrl_chk (
  .ref_clk_in, .nrst_in, .temp_check_en_in, .read_onewire_in, .read_i2c_in, .osc_fail_in,
  .mem_check_err_in, .bridge_open_in, .bridge_short_in, .temp_fault_in, .dac_code_out,
  .pin_drive_en_out, .analog_active_out, .work_mode_out, .out_mode_out, .read_data_out,
  .read_valid_out, .read_refused_out);

//--- dv/test_sensor_system_control.sv
// Self-checking bench for sensor_system_control: output mode table, then hand cases.
// Assumes the bound checker and the calibration master model sit beside the design.
`timescale 1ns/1ps
`include "sensor_ctrl_map.vh"
module test_sensor_system_control;
  typedef struct packed {logic [1:0] mode; logic early; logic late; logic refuse;} row_t;
  localparam SETTLE = 20, CONF = 20, WIN = 100, CONV = 8;
  reg         ref_clk_in = 1'b0;
  reg         nrst_in = 1'b0;
  reg  [1:0]  cfg_out_mode_in = 2'h0;
  reg         cfg_signature_ok_in = 1'b1, cfg_load_done_in = 1'b0, par_bad = 1'b0;
  reg         temp_check_en_in = 1'b1, sample_valid_in = 1'b0, wdog_kick_in = 1'b1;
  reg  [15:0] coef_gain_in = 16'h4000, bridge_raw_in = 16'h0000, temp_raw_in = 16'h0000;
  reg  [14:0] limit_low_in = 15'h0000, limit_high_in = 15'h7fff;
  reg  [4:0]  fail_r = 5'h00;
  wire        cmd_enter_in, cmd_set_mode_in, cmd_exit_in, comm_activity_in;
  wire        read_onewire_in, read_i2c_in, pin_drive_en_out, analog_active_out;
  wire        startup_done_out, window_open_out, read_valid_out, read_refused_out, fail_out;
  wire [1:0]  cmd_mode_in, work_mode_out, out_mode_out;
  wire [15:0] dac_code_out, read_data_out;
  // Even parity over the stored set; par_bad spoils it on purpose
  wire cfg_parity_in = ^{cfg_out_mode_in, coef_gain_in, limit_low_in, limit_high_in} ^ par_bad;
  int         err_total = 0, checks = 0;
  integer     i;
  row_t       rows [0:3] = '{'{`OMODE_ONEWIRE_ONLY, 1'b0, 1'b0, 1'b0},
    '{`OMODE_WINDOW, 1'b0, 1'b1, 1'b0}, '{`OMODE_ANALOG_SHARED, 1'b1, 1'b1, 1'b0},
    '{`OMODE_ONEWIRE_DIS, 1'b1, 1'b1, 1'b1}};
  // ****************
  // Design and master
  // ****************
  sensor_system_control #(.SETTLE_CYCLES(SETTLE), .CONFIG_CYCLES(CONF), .WINDOW_CYCLES(WIN),
    .CONV_CYCLES(CONV)) i_sensor_system_control (
    .ref_clk_in, .nrst_in, .cfg_out_mode_in, .cfg_signature_ok_in, .cfg_load_done_in,
    .cfg_parity_in, .temp_check_en_in, .coef_offset_in(16'h0000), .coef_gain_in,
    .coef_tc1_in(16'h0000), .coef_tc2_in(16'h0000), .coef_nl2_in(16'h0000),
    .coef_nl3_in(16'h0000), .limit_low_in, .limit_high_in, .sample_valid_in, .bridge_raw_in,
    .temp_raw_in, .cmd_enter_in, .cmd_set_mode_in, .cmd_mode_in, .cmd_exit_in,
    .comm_activity_in, .read_onewire_in, .read_i2c_in, .wdog_kick_in, .osc_fail_in(fail_r[0]),
    .mem_check_err_in(fail_r[1]), .bridge_open_in(fail_r[2]), .bridge_short_in(fail_r[3]),
    .temp_fault_in(fail_r[4]), .dac_code_out, .pin_drive_en_out, .analog_active_out,
    .work_mode_out, .out_mode_out, .startup_done_out, .window_open_out, .read_data_out,
    .read_valid_out, .read_refused_out, .fail_out);
  cal_master_model i_cal_master_model (.ref_clk_in, .read_data_in(read_data_out),
    .read_valid_in(read_valid_out), .read_refused_in(read_refused_out),
    .cmd_enter_out(cmd_enter_in), .comm_activity_out(comm_activity_in),
    .read_onewire_out(read_onewire_in), .read_i2c_out(read_i2c_in), .cmd_exit_out(cmd_exit_in),
    .cmd_set_mode_out(cmd_set_mode_in), .cmd_mode_out(cmd_mode_in));
  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // ****************
  // Checks and waits
  // ****************
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    begin
      checks++;
      if (got !== exp) begin
        err_total++;
        $display("MISMATCH %0t %s got %h want %h", $time, msg, got, exp);
      end
    end
  endtask
  task chk_bit(input logic got, input logic exp, input string msg);
    chk_word({15'h0000, got}, {15'h0000, exp}, msg);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // Waits on 0 startup end, 1 open window, 2 failure flag; watchdog needs the long bound
  task wait_for(input integer sel);
    integer n;
    begin
      n = 0;
      while ((sel == 0 ? startup_done_out : sel == 1 ? window_open_out : fail_out) !== 1'b1
             && n < 1100) begin
        @(posedge ref_clk_in);
        n++;
      end
      if (n == 1100) begin
        err_total++;
        $display("MISMATCH %0t wait ran out", $time);
        end_of_test;
      end
    end
  endtask
  task boot(input [1:0] m, input ok, input early);
    begin
      nrst_in <= 1'b0;
      cfg_out_mode_in <= m;
      cfg_signature_ok_in <= ok;
      fail_r <= 5'h00;
      par_bad <= 1'b0;
      wdog_kick_in <= 1'b1;
      tick(10);
      nrst_in <= 1'b1;
      tick(SETTLE / 2);
      chk_bit(pin_drive_en_out, 1'b0, "pin in settle");
      tick(SETTLE / 2 + CONF / 2);
      chk_bit(pin_drive_en_out, 1'b1, "pin in config");
      chk_word(dac_code_out, `DIAG_LOW_CODE, "config level");
      tick(CONF / 2 + CONV * 2);
      chk_bit(pin_drive_en_out, early | !ok, "pin in start routine");
    end
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    for (i = 0; i < 4; i++) begin
      boot(rows[i].mode, 1'b1, rows[i].early);
      wait_for(0);
      tick(2);
      chk_bit(analog_active_out, rows[i].early, "analog at startup end");
      tick(WIN + 10);
      chk_bit(analog_active_out, rows[i].late, "analog in run");
      chk_bit(pin_drive_en_out, rows[i].late, "pin in run");
      chk_bit(window_open_out, 1'b0, "window closed");
      chk_word(out_mode_out, rows[i].mode, "output mode");
      chk_word(work_mode_out, `WMODE_NORMAL, "working mode");
      i_cal_master_model.send(3'h2, 2'h0);
      chk_bit(i_cal_master_model.refused_r, rows[i].refuse, "one-wire refusal");
      i_cal_master_model.send(3'h3, 2'h0);
      chk_bit(i_cal_master_model.valid_r & ~i_cal_master_model.data_r[15], 1'b1, "read");
    end
    boot(`OMODE_WINDOW, 1'b1, 1'b0);
    // Traffic only counts once the window phase itself has begun
    wait_for(0);
    i_cal_master_model.send(3'h1, 2'h0);
    tick(WIN + 10);
    chk_bit(analog_active_out, 1'b0, "analog after traffic");
    for (i = 1; i < 3; i++) begin
      boot(i[1:0], 1'b1, i == 2);
      wait_for(1);
      wait_for(0);
      i_cal_master_model.send(3'h0, 2'h0);
      tick(WIN + 10);
      chk_word(work_mode_out, `WMODE_COMMAND, "command entry");
      chk_bit(analog_active_out, 1'b0, "analog in command mode");
    end
    i_cal_master_model.send(3'h5, `OMODE_ONEWIRE_DIS);
    i_cal_master_model.send(3'h4, 2'h0);
    tick(2);
    chk_word(out_mode_out, `OMODE_ONEWIRE_DIS, "mode by command");
    chk_bit(analog_active_out, 1'b1, "analog after exit");
    boot(`OMODE_ONEWIRE_DIS, 1'b0, 1'b1);
    chk_word(work_mode_out, `WMODE_DIAG, "bad signature");
    cfg_load_done_in <= 1'b1;
    boot(`OMODE_ONEWIRE_DIS, 1'b1, 1'b1);
    wait_for(0);
    limit_low_in <= 15'h1234;
    limit_high_in <= 15'h1234;
    bridge_raw_in <= 16'h2000;
    temp_raw_in <= 16'h0100;
    sample_valid_in <= 1'b1;
    tick(1);
    sample_valid_in <= 1'b0;
    tick(4);
    chk_word(dac_code_out, 16'h2468, "clipped code");
    for (i = 0; i < 7; i++) begin
      boot(`OMODE_ANALOG_SHARED, 1'b1, 1'b1);
      wait_for(0);
      if (i < 5)
        fail_r[i] <= 1'b1;
      else if (i == 5)
        par_bad <= 1'b1;
      else
        wdog_kick_in <= 1'b0;
      wait_for(2);
      tick(2);
      chk_word(work_mode_out, `WMODE_DIAG, "failure mode");
      chk_word(dac_code_out, `DIAG_LOW_CODE, "failure level");
      i_cal_master_model.send(3'h3, 2'h0);
      chk_word(i_cal_master_model.data_r, `ERROR_CODE, "error code");
    end
    end_of_test;
  end
endmodule // test_sensor_system_control
